// ===== src/event_capture_consts.svh
// Constants of the timestamped event capture unit: offsets, fields, reset values and timing counts.
`ifndef EVENT_CAPTURE_CONSTS_SVH
`define EVENT_CAPTURE_CONSTS_SVH

// ****************************************
// Register indices and address width
// ****************************************
`define IDX_EDGE_SELECT_MODE 8'h03
`define IDX_IO_CONTROL_FIRST 8'h15
`define IDX_IO_CONTROL_SECOND 8'h16
`define IDX_EVENT_TIME_WORD 8'h04
`define IDX_EVENT_FLAGS_BYTE 8'h06
`define IDX_CAPTURE_TIMEBASE 8'h0a
`define IDX_INT_STATUS 8'h08
`define IDX_INT_MASK 8'h09
`define IDX_PIN_LEVELS 8'h0b
`define ADDR_W 12

// ****************************************
// Field layouts
// ****************************************
`define MODE_EVERY_EIGHTH 2'h0
`define MODE_RISING 2'h1
`define MODE_FALLING 2'h2
`define MODE_BOTH 2'h3
`define IOC2_FIFO_LEVEL_BIT 0
`define INT_OVERFLOW_BIT 0
`define INT_FIFO_BIT 1
`define INT_LOST_BIT 2
`define INT_W 3

// ****************************************
// Reset values
// ****************************************
`define RESET_MODE 8'h00
`define RESET_IOC 8'h00
`define RESET_MASK 3'h0

// ****************************************
// Timing, depth and response codes
// ****************************************
`define STATE_TIME_NS 20
`define PRESCALE_STATES 8
`define PRESCALE_CYCLES (`PRESCALE_STATES * `STATE_TIME_NS / 20)
`define FIFO_DEPTH 8
`define FIFO_NEAR_FULL 7
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ===== src/event_capture_pkg.sv
// Types shared by the timestamped event capture unit.
package event_capture_pkg;

    // One stored event: four change bits and the timebase value.
    typedef struct packed {
        logic [3:0] change;
        logic [15:0] stamp;
    } fifo_entry_t;

    // Read response state of the bus slave.
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_RESP
    } rd_state_t;

endpackage

// ===== src/timestamped_event_capture.sv
// Four-pin timestamped event capture unit with an AXI4-Lite register slave.
//
// Contract
// - Two-bit mode per input selects edges.
// - Edge-select mode register at location 3.
// - First control register at 15H disconnects inputs.
// - Disconnected inputs remain readable; two feed outputs.
// - Selected change pushes change mask plus time.
// - Timebase increments every eight state times.
// - Timebase clears at reset, read-only, free running.
// - Timebase rollover sets flag and interrupts.
// - Eight-entry, twenty-bit event FIFO.
// - Reading holding register advances next oldest.
// - FIFO interrupt at one or seven entries.
// - Time word and status byte separate registers.
// - Status upper bits show live pin levels.
// - Time read pops; status read harmless.
// - Bit zero connects first input to FIFO.
//
// The AXI4-Lite register port was chosen for this implementation.
`include "event_capture_consts.svh"
module timestamped_event_capture (
    // Clock, reset and enable.
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // Event pins.
    input wire logic [3:0] EVENT_INPUT,
    output logic [1:0] SCHEDULED_OUTPUT_INPUTS,
    output logic IRQ,
    // AXI4-Lite write address and data.
    input wire logic [`ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response.
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read.
    input wire logic [`ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0] mode_reg;
    logic [7:0] ioc_first_reg;
    logic [7:0] ioc_second_reg;
    logic [`INT_W-1:0] int_status_reg;
    logic [`INT_W-1:0] int_mask_reg;
    logic [15:0] timebase_reg;
    logic [2:0] prescale_reg;
    logic [3:0] pin_prev_reg;
    logic [2:0] eighth_cnt_reg [3:0];
    event_capture_pkg::fifo_entry_t fifo_mem [`FIFO_DEPTH-1:0];
    logic [3:0] fifo_count_reg;
    logic [3:0] change;
    logic push;
    logic pop;
    logic tick;
    logic rollover;
    logic aw_held_reg;
    logic w_held_reg;
    logic [`ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;
    logic [7:0] wr_idx;
    logic wr_hit;
    event_capture_pkg::rd_state_t rd_state_reg;
    logic [7:0] rd_idx;
    logic [31:0] rd_data_next;
    logic rd_hit_next;
    logic fifo_irq_cond;

    // ****************************************
    // Timebase
    // ****************************************

    // Prescaler gives one tick per eight state times of 20 ns each.
    assign tick = (prescale_reg == 3'(`PRESCALE_CYCLES - 1));
    assign rollover = tick && (timebase_reg == 16'hffff);

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            prescale_reg <= 3'h0;
        else if (CE)
            prescale_reg <= tick ? 3'h0 : prescale_reg + 3'h1;
    end

    // Free running counter; bus writes never reach it.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            timebase_reg <= 16'h0000;
        else if (CE && tick)
            timebase_reg <= timebase_reg + 16'h0001;
    end

    // ****************************************
    // Edge detection
    // ****************************************

    // Pins are taken as synchronous; the previous sample gives the edge.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            pin_prev_reg <= 4'h0;
        else if (CE)
            pin_prev_reg <= EVENT_INPUT;
    end

    // Per-pin qualification; disconnected pins record nothing but stay readable.
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : pin_gen
            logic rise;
            logic fall;
            logic [1:0] m;
            assign rise = EVENT_INPUT[g] && !pin_prev_reg[g];
            assign fall = !EVENT_INPUT[g] && pin_prev_reg[g];
            assign m = mode_reg[2*g +: 2];

            // Counts rising edges in every-eighth mode; the eighth is recorded.
            always_ff @(posedge CLK)
            begin
                if (!RST_N)
                    eighth_cnt_reg[g] <= 3'h0;
                else if (CE && rise && ioc_first_reg[g] && m == `MODE_EVERY_EIGHTH)
                    eighth_cnt_reg[g] <= eighth_cnt_reg[g] + 3'h1;
            end

            always_comb
            begin
                change[g] = 1'b0;
                if (ioc_first_reg[g])
                begin
                    case (m)
                        `MODE_EVERY_EIGHTH: change[g] = rise && (eighth_cnt_reg[g] == 3'h7);
                        `MODE_RISING: change[g] = rise;
                        `MODE_FALLING: change[g] = fall;
                        default: change[g] = rise || fall;
                    endcase
                end
            end
        end
    endgenerate

    // Third and fourth pins go to the output unit once disconnected.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            SCHEDULED_OUTPUT_INPUTS <= 2'h0;
        else if (CE)
            SCHEDULED_OUTPUT_INPUTS <= EVENT_INPUT[3:2] & ~ioc_first_reg[3:2];
    end

    // ****************************************
    // Event FIFO
    // ****************************************

    // Entry 0 is the holding register; a full FIFO drops new events.
    assign push = (change != 4'h0) && (fifo_count_reg != 4'(`FIFO_DEPTH));

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            fifo_count_reg <= 4'h0;
        else if (CE)
            fifo_count_reg <= fifo_count_reg + 4'(push) - 4'(pop);
    end

    // Shift on pop so the next oldest falls into the holding slot.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            for (int i = 0; i < `FIFO_DEPTH; i++)
                fifo_mem[i] <= '0;
        end
        else if (CE)
        begin
            for (int i = 0; i < `FIFO_DEPTH; i++)
            begin
                if (push && (32'(fifo_count_reg) - 32'(pop)) == i)
                    fifo_mem[i] <= '{change: change, stamp: timebase_reg};
                else if (pop)
                    fifo_mem[i] <= (i == `FIFO_DEPTH - 1) ? '0 : fifo_mem[i + 1];
            end
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    assign fifo_irq_cond = ioc_second_reg[`IOC2_FIFO_LEVEL_BIT] ?
        (fifo_count_reg >= 4'(`FIFO_NEAR_FULL)) : (fifo_count_reg != 4'h0);

    // Set wins over a same-cycle write-one clear.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            int_status_reg <= '0;
        else if (CE)
        begin
            int_status_reg <= (int_status_reg & ~((wr_hit && wr_idx == `IDX_INT_STATUS) ?
                w_data_reg[`INT_W-1:0] : 3'h0))
                | {(change != 4'h0) && !push, fifo_irq_cond, rollover};
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            IRQ <= 1'b0;
        else if (CE)
            IRQ <= |(int_status_reg & int_mask_reg);
    end

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    assign AWREADY = !aw_held_reg && !BVALID;
    assign WREADY = !w_held_reg && !BVALID;
    assign wr_fire = aw_held_reg && w_held_reg && !BVALID;
    assign wr_idx = aw_addr_reg[9:2];
    assign wr_hit = CE && wr_fire && w_strb_reg[0] && (aw_addr_reg[`ADDR_W-1:10] == '0);

    // Address and data are caught in either order.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end
        else if (CE)
        begin
            if (AWVALID && AWREADY)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= AWADDR;
            end
            else if (wr_fire)
                aw_held_reg <= 1'b0;
            if (WVALID && WREADY)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= WDATA;
                w_strb_reg <= WSTRB;
            end
            else if (wr_fire)
                w_held_reg <= 1'b0;
        end
    end

    // Writable control; unmapped writes answer DECERR.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            mode_reg <= `RESET_MODE;
            ioc_first_reg <= `RESET_IOC;
            ioc_second_reg <= `RESET_IOC;
            int_mask_reg <= `RESET_MASK;
        end
        else if (wr_hit)
        begin
            if (wr_idx == `IDX_EDGE_SELECT_MODE)
                mode_reg <= w_data_reg[7:0];
            else if (wr_idx == `IDX_IO_CONTROL_FIRST)
                ioc_first_reg <= w_data_reg[7:0];
            else if (wr_idx == `IDX_IO_CONTROL_SECOND)
                ioc_second_reg <= w_data_reg[7:0];
            else if (wr_idx == `IDX_INT_MASK)
                int_mask_reg <= w_data_reg[`INT_W-1:0];
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            BVALID <= 1'b0;
            BRESP <= `RESP_OKAY;
        end
        else if (CE)
        begin
            if (wr_fire)
            begin
                BVALID <= 1'b1;
                BRESP <= (aw_addr_reg[9:2] == `IDX_EDGE_SELECT_MODE || aw_addr_reg[9:2] == `IDX_IO_CONTROL_FIRST ||
                    aw_addr_reg[9:2] == `IDX_IO_CONTROL_SECOND || aw_addr_reg[9:2] == `IDX_INT_MASK ||
                    aw_addr_reg[9:2] == `IDX_INT_STATUS || aw_addr_reg[9:2] == `IDX_CAPTURE_TIMEBASE)
                    && aw_addr_reg[`ADDR_W-1:10] == '0 ? `RESP_OKAY : `RESP_DECERR;
            end
            else if (BREADY)
                BVALID <= 1'b0;
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    assign ARREADY = (rd_state_reg == event_capture_pkg::RD_IDLE);
    assign rd_idx = ARADDR[9:2];
    assign pop = CE && ARVALID && ARREADY && rd_hit_next && rd_idx == `IDX_EVENT_TIME_WORD
        && fifo_count_reg != 4'h0;

    // Read mux; status byte keeps live pins in its upper nibble.
    always_comb
    begin
        rd_data_next = 32'h0;
        rd_hit_next = (ARADDR[`ADDR_W-1:10] == '0);
        if (rd_idx == `IDX_EVENT_TIME_WORD)
            rd_data_next = {16'h0, fifo_mem[0].stamp};
        else if (rd_idx == `IDX_EVENT_FLAGS_BYTE)
            rd_data_next = {24'h0, EVENT_INPUT, fifo_mem[0].change};
        else if (rd_idx == `IDX_CAPTURE_TIMEBASE)
            rd_data_next = {16'h0, timebase_reg};
        else if (rd_idx == `IDX_INT_STATUS)
            rd_data_next = {29'h0, int_status_reg};
        else if (rd_idx == `IDX_INT_MASK)
            rd_data_next = {29'h0, int_mask_reg};
        else if (rd_idx == `IDX_IO_CONTROL_SECOND)
            rd_data_next = {24'h0, ioc_second_reg};
        else if (rd_idx == `IDX_PIN_LEVELS)
            rd_data_next = {28'h0, EVENT_INPUT};
        else
            rd_hit_next = 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            rd_state_reg <= event_capture_pkg::RD_IDLE;
            RVALID <= 1'b0;
            RDATA <= 32'h0;
            RRESP <= `RESP_OKAY;
        end
        else if (CE)
        begin
            case (rd_state_reg)
                event_capture_pkg::RD_IDLE:
                begin
                    if (ARVALID)
                    begin
                        rd_state_reg <= event_capture_pkg::RD_RESP;
                        RVALID <= 1'b1;
                        RDATA <= rd_hit_next ? rd_data_next : 32'h0;
                        RRESP <= rd_hit_next ? `RESP_OKAY : `RESP_DECERR;
                    end
                end
                default:
                begin
                    if (RREADY)
                    begin
                        rd_state_reg <= event_capture_pkg::RD_IDLE;
                        RVALID <= 1'b0;
                    end
                end
            endcase
        end
    end

endmodule

// ===== tb/event_capture_checker.sv
// Concurrent checks on the ports of the event capture unit.
`include "event_capture_consts.svh"
module event_capture_checker (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_N,
    // Pins.
    input wire logic [3:0] EVENT_INPUT,
    input wire logic [1:0] SCHEDULED_OUTPUT_INPUTS,
    input wire logic IRQ,
    // Write channels.
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY,
    // Read channels.
    input wire logic [`ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    input wire logic RREADY
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Bus and pin relations
    // ****************************************
    // All checks share one clock; reset masks all but the reset check.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    chk_rd_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer missing");
    chk_rd_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("read answer dropped early");
    chk_rd_single: assert property (RVALID |-> !ARREADY)
        else $error("second read taken while answering");
    chk_wr_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write answer missing");
    chk_wr_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write answer dropped early");
    chk_wr_single: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while answering");
    chk_rd_unmapped: assert property (ARVALID && ARREADY && ARADDR == 12'h0fc |=> RRESP == 2'h3 && RDATA == 32'h0)
        else $error("unmapped read not refused");
    // A pin that was low cannot show high on the scheduled output side.
    chk_sched_gated: assert property ((SCHEDULED_OUTPUT_INPUTS & ~$past(EVENT_INPUT[3:2])) == 2'h0)
        else $error("scheduled output input not from pin");
    chk_reset_quiet: assert property (disable iff (1'b0) !RST_N |=> !BVALID && !RVALID && !IRQ)
        else $error("outputs active after reset");
endmodule

bind timestamped_event_capture event_capture_checker chk (.CLK(CLK), .RST_N(RST_N), .EVENT_INPUT(EVENT_INPUT),
    .SCHEDULED_OUTPUT_INPUTS(SCHEDULED_OUTPUT_INPUTS), .IRQ(IRQ), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

// ===== tb/event_source.sv
// Behavioural model of the four pulse sources that feed the event pins.
module event_source (
    // Clock.
    input wire logic clk,
    // Event pins.
    output logic [3:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Pulse trains
    // ****************************************
    // Sources idle low; every train ends at that level.
    initial pins = 4'h0;

    // Toggles one pin each half period, just after an edge, for n whole pulses.
    task automatic pulses(input int pin, input int n, input int half);
        repeat (2 * n)
        begin
            repeat (half) @(posedge clk);
            pins[pin] <= ~pins[pin];
        end
    endtask

    // Moves all pins at once, which yields simultaneous changes.
    task automatic set_pins(input logic [3:0] v);
        @(posedge clk);
        pins <= v;
    endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench of the timestamped event capture unit.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [1:0] mode; int pulses; int count; int dstamp;} row_t;
    // Pin i runs mode i; both-edge row overruns the FIFO on purpose.
    row_t rows [4] = '{'{2'h0, 9, 1, 0}, '{2'h1, 3, 3, 2}, '{2'h2, 3, 3, 2}, '{2'h3, 6, 8, 1}};
    logic clk, rst_n, ce, awvalid, wvalid, bready, arvalid, rready, irq, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, sched;
    wire logic [3:0] pins;
    int fails = 0;
    int compares = 0;

    event_source src (.clk(clk), .pins(pins));
    timestamped_event_capture dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .EVENT_INPUT(pins),
        .SCHEDULED_OUTPUT_INPUTS(sched), .IRQ(irq), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

    // Free-running 50 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Write with address and data offered together; only the watchdog ends a wait that hangs.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw, w;
        aw = 1;
        w = 1;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (1'b1)
        begin
            @(posedge clk);
            if (!aw && !w && bvalid)
                break;
            if (aw && awready)
            begin
                aw = 0;
                awvalid <= 1'b0;
            end
            if (w && wready)
            begin
                w = 0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
        compare_word({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        bit ar;
        ar = 1;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (1'b1)
        begin
            @(posedge clk);
            if (!ar && rvalid)
                break;
            if (ar && arready)
            begin
                ar = 0;
                arvalid <= 1'b0;
            end
        end
        d = rdata;
        rready <= 1'b0;
        compare_word({30'h0, rresp}, {30'h0, er});
    endtask

    // Empties the FIFO, checking change bits, live pins and stamp spacing (ds 0 skips spacing).
    task automatic drain(input logic [3:0] ch, input int ds, output int cnt);
        logic [31:0] f, g, t, p;
        cnt = 0;
        p = 32'h0;
        repeat (10)
        begin
            rd(12'h018, f, 2'h0);
            rd(12'h018, g, 2'h0);
            compare_word(g, f);
            compare_word({28'h0, f[7:4]}, {28'h0, pins});
            if (f[3:0] === 4'h0)
                break;
            compare_word({28'h0, f[3:0]}, {28'h0, ch});
            rd(12'h010, t, 2'h0);
            if (ds > 0 && cnt > 0)
                compare_word({16'h0, t[15:0] - p[15:0]}, 32'(ds));
            p = t;
            cnt++;
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        int cnt;
        logic [31:0] v, u;
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        ce = 1'b1;
        awaddr = 12'h0;
        araddr = 12'h0;
        wdata = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            wr(12'h00c, 32'(rows[i].mode) << (2 * i), 2'h0);
            wr(12'h054, 32'h1 << i, 2'h0);
            src.pulses(i, rows[i].pulses, 8);
            repeat (4) @(posedge clk);
            drain(4'(1 << i), rows[i].dstamp, cnt);
            compare_word(32'(cnt), 32'(rows[i].count));
            $display("Row %0d done", i);
        end
        rd(12'h020, v, 2'h0);
        compare_word(v & 32'h6, 32'h6);
        wr(12'h020, 32'h7, 2'h0);
        rd(12'h020, v, 2'h0);
        compare_word(v, 32'h0);
        $display("Lost event flag test done");
        // Disconnected pins stay readable and reach the scheduled output side.
        wr(12'h00c, 32'hff, 2'h0);
        wr(12'h054, 32'h0, 2'h0);
        src.set_pins(4'hd);
        repeat (4) @(posedge clk);
        compare_word({30'h0, sched}, 32'h3);
        drain(4'h0, 0, cnt);
        compare_word(32'(cnt), 32'h0);
        wr(12'h054, 32'hc, 2'h0);
        repeat (4) @(posedge clk);
        compare_word({30'h0, sched}, 32'h0);
        src.set_pins(4'h0);
        repeat (4) @(posedge clk);
        drain(4'hc, 0, cnt);
        compare_word(32'(cnt), 32'h1);
        $display("Disconnect test done");
        // Near-full interrupt threshold, then masking.
        wr(12'h00c, 32'h04, 2'h0);
        wr(12'h054, 32'h2, 2'h0);
        wr(12'h058, 32'h1, 2'h0);
        wr(12'h024, 32'h2, 2'h0);
        src.pulses(1, 6, 4);
        repeat (4) @(posedge clk);
        wr(12'h020, 32'h7, 2'h0);
        repeat (3) @(posedge clk);
        compare_word({31'h0, irq}, 32'h0);
        src.pulses(1, 1, 4);
        repeat (4) @(posedge clk);
        compare_word({31'h0, irq}, 32'h1);
        wr(12'h024, 32'h0, 2'h0);
        repeat (3) @(posedge clk);
        compare_word({31'h0, irq}, 32'h0);
        drain(4'h2, 0, cnt);
        compare_word(32'(cnt), 32'h7);
        $display("Interrupt test done");
        // Timebase ignores writes and keeps counting; unmapped places are refused.
        rd(12'h028, v, 2'h0);
        wr(12'h028, 32'h0, 2'h0);
        repeat (80) @(posedge clk);
        rd(12'h028, u, 2'h0);
        compare_word(32'((u[15:0] - v[15:0]) inside {[16'd10:16'd12]}), 32'h1);
        // A low clock enable must freeze the timebase; at most one tick slips in at the ends.
        ce <= 1'b0;
        repeat (80) @(posedge clk);
        ce <= 1'b1;
        rd(12'h028, v, 2'h0);
        compare_word(32'((v[15:0] - u[15:0]) inside {[16'd0:16'd1]}), 32'h1);
        rd(12'h0fc, v, 2'h3);
        wr(12'h0fc, 32'h0, 2'h3);
        $display("Timebase test done");
        // Reset in mid-run drops stored events and disconnects every pin.
        wr(12'h054, 32'hf, 2'h0);
        src.pulses(1, 2, 4);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(12'h028, v, 2'h0);
        compare_word(32'(v < 32'h4), 32'h1);
        src.pulses(1, 2, 4);
        repeat (4) @(posedge clk);
        drain(4'h0, 0, cnt);
        compare_word(32'(cnt), 32'h0);
        $display("Reset test done");
        summarize();
    end

    // Watchdog well beyond the roughly one thousand cycles the tests need.
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule
